// file: inc/panel_regs.vh
// Constants shared by the front-panel display and diagnosis logic.
// Assumes a 5-digit panel driven with 5-bit glyph codes per digit.
`ifndef PANEL_REGS_VH
`define PANEL_REGS_VH

// Glyph codes: 0x00..0x0F are the hex digits themselves
`define GLYPH_BLANK     5'h10
`define GLYPH_HIGH      5'h11
`define GLYPH_LOW       5'h12
`define GLYPH_J         5'h13
`define GLYPH_G         5'h14
`define GLYPH_ZERO      5'h00

// Decimal point masks, bit 0 is the rightmost digit
`define DP_NONE         5'h00
`define DP_NEGATIVE     5'h18
`define DP_HIGH_PAGE    5'h02

// Special-function codes
`define SF_FORCE_ON     16'h0196
`define SF_FORCE_OFF    16'h0190

// Parameter selections while in parameter mode
`define SEL_FAULT_LAST  3'h4
`define SEL_JOG_SPEED   3'h5
`define SEL_FORCE_PAT   3'h6

// Diagnosis display selection
`define DIAG_NONE       2'h0
`define DIAG_INPUTS     2'h1
`define DIAG_OUTPUTS    2'h2

// Jog speed in r/min
`define JOG_DEFAULT     16'h0014
`define JOG_MIN         16'h0001
`define JOG_MAX         16'h1388

// Binary to BCD converter
`define BCD_LAST_STEP   6'h1F
`define BCD_ADJ_MIN     4'h5
`define BCD_ADJ         4'h3

`endif

// file: rtl/bcd_convert.v
// Sequential 32-bit binary to 10-digit BCD converter (shift and add 3).
// Assumes a single clock; one conversion takes 32 enabled cycles.
`timescale 1ns/1ps
`include "panel_regs.vh"

module bcd_convert (
    input  wire        clk,
    input  wire        rst,
    input  wire        ce,
    input  wire        start,
    input  wire [31:0] bin,
    output wire        busy,
    output reg  [39:0] bcd
);

    reg  [31:0] sh_q;
    reg  [39:0] acc_q;
    reg  [5:0]  cnt_q;
    reg         busy_q;
    wire [39:0] adj;

    // Add 3 to every BCD digit that is 5 or more before the next shift
    genvar g;
    generate
        for (g = 0; g < 10; g = g + 1) begin : digit
            assign adj[4*g+3:4*g] = (acc_q[4*g+3:4*g] >= `BCD_ADJ_MIN) ?
                                    acc_q[4*g+3:4*g] + `BCD_ADJ : acc_q[4*g+3:4*g];
        end
    endgenerate

    assign busy = busy_q;

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_q   <= 32'h0;
            acc_q  <= 40'h0;
            cnt_q  <= 6'h0;
            busy_q <= 1'b0;
            bcd    <= 40'h0;
        end else if (ce) begin
            if (!busy_q) begin
                if (start) begin
                    sh_q   <= bin;
                    acc_q  <= 40'h0;
                    cnt_q  <= 6'h0;
                    busy_q <= 1'b1;
                end
            end else begin
                sh_q  <= {sh_q[30:0], 1'b0};
                acc_q <= {adj[38:0], sh_q[31]};
                cnt_q <= cnt_q + 6'h1;
                if (cnt_q == `BCD_LAST_STEP) begin
                    busy_q <= 1'b0;
                    bcd    <= {adj[38:0], sh_q[31]};
                end
            end
        end
    end

endmodule

// file: rtl/panel_monitor_display_diag.v
// Front-panel logic: value formatting for a 5-digit display, fault history view,
// keypad jog, forced digital outputs and digital I/O diagnosis displays.
// Assumes keys are synchronous, debounced levels, high while pressed.
`timescale 1ns/1ps
`include "panel_regs.vh"

module panel_monitor_display_diag (
    // Clock and reset
    input  wire        CLK_SYS,
    input  wire        RESET,
    input  wire        CLK_EN,
    // Keypad levels
    input  wire        KEY_SET,
    input  wire        KEY_MODE,
    input  wire        KEY_UP,
    input  wire        KEY_DOWN,
    input  wire        KEY_SHIFT,
    // Monitored value
    input  wire [31:0] MON_VALUE,
    input  wire        MON_IS_32,
    input  wire        MON_SIGNED,
    // Parameter view
    input  wire        PANEL_PARAM,
    input  wire [2:0]  PARAM_SEL,
    input  wire [31:0] PARAM_VALUE,
    input  wire        PARAM_IS_32,
    input  wire        PARAM_HEX,
    input  wire        PARAM_SIGNED,
    input  wire [79:0] FAULT_HISTORY_SLOTS,
    // Parameter writes
    input  wire        SPECIAL_FUNCTION_WR,
    input  wire [15:0] SPECIAL_FUNCTION_PARAM,
    input  wire        FORCE_PATTERN_WR,
    input  wire [5:0]  FORCE_PATTERN_DATA,
    // Drive state and digital I/O
    input  wire        SERVO_ON,
    input  wire [1:0]  DIAG_SEL,
    input  wire [8:0]  DIGITAL_INPUTS_1_TO_9,
    input  wire [5:0]  NORMAL_OUTPUTS,
    output reg  [5:0]  DIGITAL_OUTPUTS_1_TO_6,
    output reg         FORCE_ACTIVE,
    output reg  [5:0]  OUTPUT_FORCE_PATTERN,
    // Jog
    output reg  [15:0] JOG_SPEED_PARAM,
    output reg         JOG_ACTIVE,
    output reg         JOG_FWD,
    output reg         JOG_REV,
    // Display
    output reg  [24:0] DISP_GLYPHS,
    output reg  [4:0]  DISP_POINTS,
    output reg         DISP_PAGE_HIGH,
    output reg         DISP_HEX
);

    localparam ST_VIEW   = 2'h0;
    localparam ST_FAULT  = 2'h1;
    localparam ST_JOGSPD = 2'h2;
    localparam ST_JOG    = 2'h3;

    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg         set_q;
    reg         mode_q;
    reg         up_q;
    reg         down_q;
    reg         shift_q;
    reg         page_q;
    reg         mon_hex_q;
    reg  [2:0]  fault_idx_q;
    reg  [15:0] jog_speed_d;

    wire        set_press   = KEY_SET & ~set_q;
    wire        mode_press  = KEY_MODE & ~mode_q;
    wire        up_press    = KEY_UP & ~up_q;
    wire        down_press  = KEY_DOWN & ~down_q;
    wire        shift_press = KEY_SHIFT & ~shift_q;

    // Selected source and its format
    reg  [31:0] val;
    reg         w32;
    reg         hex;
    reg         sgn;
    reg         jog_glyph;
    wire        neg;
    wire [15:0] mag16;
    wire [31:0] mag;
    wire        conv_busy;
    wire [39:0] bcd;
    reg  [24:0] glyphs_d;
    reg  [4:0]  points_d;
    wire        page_high;

    // Source selection
    always @* begin
        val       = MON_VALUE;
        w32       = MON_IS_32;
        hex       = mon_hex_q;
        sgn       = MON_SIGNED;
        jog_glyph = 1'b0;
        if (state_q == ST_JOG) begin
            jog_glyph = 1'b1;
        end else if (DIAG_SEL == `DIAG_INPUTS) begin
            val = {23'h0, DIGITAL_INPUTS_1_TO_9};
            w32 = 1'b0;
            hex = 1'b1;
            sgn = 1'b0;
        end else if (DIAG_SEL == `DIAG_OUTPUTS) begin
            val = {26'h0, DIGITAL_OUTPUTS_1_TO_6};
            w32 = 1'b0;
            hex = 1'b1;
            sgn = 1'b0;
        end else if (state_q == ST_FAULT) begin
            val = {16'h0, FAULT_HISTORY_SLOTS[{fault_idx_q, 4'h0} +: 16]};
            w32 = 1'b0;
            hex = 1'b0;
            sgn = 1'b0;
        end else if (state_q == ST_JOGSPD) begin
            val = {16'h0, JOG_SPEED_PARAM};
            w32 = 1'b0;
            hex = 1'b0;
            sgn = 1'b0;
        end else if (PANEL_PARAM) begin
            if (PARAM_SEL == `SEL_FORCE_PAT) begin
                val = {26'h0, OUTPUT_FORCE_PATTERN};
                w32 = 1'b0;
                hex = 1'b1;
                sgn = 1'b0;
            end else begin
                val = PARAM_VALUE;
                w32 = PARAM_IS_32;
                hex = PARAM_HEX;
                sgn = PARAM_SIGNED;
            end
        end
    end

    // Sign and magnitude; hex never carries a sign
    assign neg   = sgn & ~hex & (w32 ? val[31] : val[15]);
    assign mag16 = neg ? (16'h0 - val[15:0]) : val[15:0];
    assign mag   = w32 ? (neg ? (32'h0 - val) : val) : {16'h0, mag16};
    assign page_high = w32 & page_q;

    bcd_convert u_bcd (
        .clk   (CLK_SYS),
        .rst   (RESET),
        .ce    (CLK_EN),
        .start (~conv_busy),
        .bin   (mag),
        .busy  (conv_busy),
        .bcd   (bcd)
    );

    // Digit composition
    always @* begin
        glyphs_d = 25'h0;
        points_d = `DP_NONE;
        if (jog_glyph) begin
            glyphs_d = {`GLYPH_BLANK, `GLYPH_BLANK, `GLYPH_J, `GLYPH_ZERO, `GLYPH_G};
        end else if (hex) begin
            if (!w32) begin
                glyphs_d = {`GLYPH_BLANK, 1'b0, val[15:12], 1'b0, val[11:8],
                            1'b0, val[7:4], 1'b0, val[3:0]};
            end else if (page_high) begin
                glyphs_d = {`GLYPH_HIGH, 1'b0, val[31:28], 1'b0, val[27:24],
                            1'b0, val[23:20], 1'b0, val[19:16]};
            end else begin
                glyphs_d = {`GLYPH_LOW, 1'b0, val[15:12], 1'b0, val[11:8],
                            1'b0, val[7:4], 1'b0, val[3:0]};
            end
        end else begin
            if (page_high) begin
                glyphs_d = {1'b0, bcd[39:36], 1'b0, bcd[35:32], 1'b0, bcd[31:28],
                            1'b0, bcd[27:24], 1'b0, bcd[23:20]};
                points_d = `DP_HIGH_PAGE;
            end else begin
                glyphs_d = {1'b0, bcd[19:16], 1'b0, bcd[15:12], 1'b0, bcd[11:8],
                            1'b0, bcd[7:4], 1'b0, bcd[3:0]};
            end
            if (neg) begin
                points_d = points_d | `DP_NEGATIVE;
            end
        end
    end

    // Panel state machine
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_VIEW: begin
                if (set_press && PANEL_PARAM) begin
                    if (PARAM_SEL <= `SEL_FAULT_LAST) begin
                        state_d = ST_FAULT;
                    end else if (PARAM_SEL == `SEL_JOG_SPEED) begin
                        state_d = ST_JOGSPD;
                    end
                end
            end
            ST_FAULT: begin
                if (set_press || mode_press) begin
                    state_d = ST_VIEW;
                end
            end
            ST_JOGSPD: begin
                if (set_press) begin
                    state_d = ST_JOG;
                end else if (mode_press) begin
                    state_d = ST_VIEW;
                end
            end
            ST_JOG: begin
                if (mode_press) begin
                    state_d = ST_VIEW;
                end
            end
            default: state_d = ST_VIEW;
        endcase
    end

    // Jog speed adjustment
    always @* begin
        jog_speed_d = JOG_SPEED_PARAM;
        if (state_q == ST_JOGSPD) begin
            if (up_press && !down_press && JOG_SPEED_PARAM < `JOG_MAX) begin
                jog_speed_d = JOG_SPEED_PARAM + 16'h0001;
            end else if (down_press && !up_press && JOG_SPEED_PARAM > `JOG_MIN) begin
                jog_speed_d = JOG_SPEED_PARAM - 16'h0001;
            end
        end
    end

    always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            state_q                <= ST_VIEW;
            set_q                  <= 1'b0;
            mode_q                 <= 1'b0;
            up_q                   <= 1'b0;
            down_q                 <= 1'b0;
            shift_q                <= 1'b0;
            page_q                 <= 1'b0;
            mon_hex_q              <= 1'b0;
            fault_idx_q            <= 3'h0;
            JOG_SPEED_PARAM        <= `JOG_DEFAULT;
            JOG_ACTIVE             <= 1'b0;
            JOG_FWD                <= 1'b0;
            JOG_REV                <= 1'b0;
            FORCE_ACTIVE           <= 1'b0;
            OUTPUT_FORCE_PATTERN   <= 6'h00;
            DIGITAL_OUTPUTS_1_TO_6 <= 6'h00;
            DISP_GLYPHS            <= 25'h0;
            DISP_POINTS            <= `DP_NONE;
            DISP_PAGE_HIGH         <= 1'b0;
            DISP_HEX               <= 1'b0;
        end else if (CLK_EN) begin
            set_q           <= KEY_SET;
            mode_q          <= KEY_MODE;
            up_q            <= KEY_UP;
            down_q          <= KEY_DOWN;
            shift_q         <= KEY_SHIFT;
            state_q         <= state_d;
            JOG_SPEED_PARAM <= jog_speed_d;
            if (state_q == ST_VIEW && set_press && PANEL_PARAM) begin
                fault_idx_q <= PARAM_SEL;
            end
            // Page and radix toggles only for 32-bit monitored variables
            if (state_q == ST_VIEW && !PANEL_PARAM && DIAG_SEL == `DIAG_NONE && MON_IS_32) begin
                if (shift_press) begin
                    page_q <= ~page_q;
                end
                if (set_press) begin
                    mon_hex_q <= ~mon_hex_q;
                end
            end
            JOG_ACTIVE <= (state_d == ST_JOG);
            JOG_FWD    <= (state_d == ST_JOG) & SERVO_ON & KEY_UP & ~KEY_DOWN;
            JOG_REV    <= (state_d == ST_JOG) & SERVO_ON & KEY_DOWN & ~KEY_UP;
            if (SPECIAL_FUNCTION_WR) begin
                if (SPECIAL_FUNCTION_PARAM == `SF_FORCE_ON) begin
                    FORCE_ACTIVE <= 1'b1;
                end else if (SPECIAL_FUNCTION_PARAM == `SF_FORCE_OFF) begin
                    FORCE_ACTIVE <= 1'b0;
                end
            end
            if (FORCE_PATTERN_WR) begin
                OUTPUT_FORCE_PATTERN <= FORCE_PATTERN_DATA;
            end
            DIGITAL_OUTPUTS_1_TO_6 <= FORCE_ACTIVE ? OUTPUT_FORCE_PATTERN : NORMAL_OUTPUTS;
            DISP_GLYPHS            <= glyphs_d;
            DISP_POINTS            <= points_d;
            DISP_PAGE_HIGH         <= page_high;
            DISP_HEX               <= hex & ~jog_glyph;
        end
    end

endmodule

// file: sim/operator_panel.sv
// Operator keypad model: key levels seen by the panel block.
// Assumes the block samples keys on rising edges; keys change on falling edges only.
`timescale 1ns/1ps
module operator_panel (
    // Clock
    input  wire       clk,
    // Key levels: set, mode, up, down, shift
    output reg  [4:0] keys
);
    initial keys = 5'h00;
    // High for two edges, low for two, so each press is a fresh rising edge
    task press(input integer k);
        begin
            @(negedge clk);
            keys[k] = 1'b1;
            repeat (2) @(negedge clk);
            keys[k] = 1'b0;
            repeat (2) @(negedge clk);
        end
    endtask
    task hold(input [4:0] lv);
        begin
            @(negedge clk);
            keys = lv;
        end
    endtask
endmodule

// file: sim/panel_checker_properties.sv
// Concurrent checks on the panel block's ports, bound to every instance.
// Assumes one clock domain and keys as synchronous levels.
`timescale 1ns/1ps
`include "panel_regs.vh"
module panel_checker (
    // Clock and reset
    input wire        CLK_SYS,
    input wire        RESET,
    input wire        CLK_EN,
    // Keys and drive state
    input wire        KEY_UP,
    input wire        KEY_DOWN,
    input wire        SERVO_ON,
    // Forced outputs
    input wire        SPECIAL_FUNCTION_WR,
    input wire [15:0] SPECIAL_FUNCTION_PARAM,
    input wire        FORCE_PATTERN_WR,
    input wire [5:0]  FORCE_PATTERN_DATA,
    input wire [5:0]  NORMAL_OUTPUTS,
    input wire [5:0]  DIGITAL_OUTPUTS_1_TO_6,
    input wire        FORCE_ACTIVE,
    input wire [5:0]  OUTPUT_FORCE_PATTERN,
    // Jog and display
    input wire        JOG_ACTIVE,
    input wire        JOG_FWD,
    input wire        JOG_REV,
    input wire [24:0] DISP_GLYPHS,
    input wire [4:0]  DISP_POINTS,
    input wire        DISP_HEX
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    sequence s_jog_req;
        CLK_EN && JOG_ACTIVE && SERVO_ON && (KEY_UP ^ KEY_DOWN);
    endsequence
    property p_force_on;
        CLK_EN && SPECIAL_FUNCTION_WR && SPECIAL_FUNCTION_PARAM == `SF_FORCE_ON |=> FORCE_ACTIVE;
    endproperty
    a_force_on: assert property (p_force_on) else $error("force mode not entered");
    property p_force_off;
        CLK_EN && SPECIAL_FUNCTION_WR && SPECIAL_FUNCTION_PARAM == `SF_FORCE_OFF |=> !FORCE_ACTIVE;
    endproperty
    a_force_off: assert property (p_force_off) else $error("force mode not left");
    property p_pattern;
        CLK_EN && FORCE_PATTERN_WR |=> OUTPUT_FORCE_PATTERN == $past(FORCE_PATTERN_DATA);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern not stored");
    property p_force_drive;
        CLK_EN && FORCE_ACTIVE |=> DIGITAL_OUTPUTS_1_TO_6 == $past(OUTPUT_FORCE_PATTERN);
    endproperty
    a_force_drive: assert property (p_force_drive) else $error("outputs not forced");
    property p_normal;
        CLK_EN && !FORCE_ACTIVE |=> DIGITAL_OUTPUTS_1_TO_6 == $past(NORMAL_OUTPUTS);
    endproperty
    a_normal: assert property (p_normal) else $error("outputs not normal");
    property p_servo_off;
        CLK_EN && !SERVO_ON |=> !JOG_FWD && !JOG_REV;
    endproperty
    a_servo_off: assert property (p_servo_off) else $error("motion without servo on");
    property p_jog_dir;
        s_jog_req |=> JOG_FWD == $past(KEY_UP) && JOG_REV == $past(KEY_DOWN);
    endproperty
    a_jog_dir: assert property (p_jog_dir) else $error("jog direction wrong");
    property p_jog_shown;
        $rose(JOG_ACTIVE) |=> DISP_GLYPHS == {`GLYPH_BLANK, `GLYPH_BLANK, `GLYPH_J, `GLYPH_ZERO, `GLYPH_G};
    endproperty
    a_jog_shown: assert property (p_jog_shown) else $error("jog indication missing");
    property p_hex_nosign;
        DISP_HEX |-> DISP_POINTS == `DP_NONE;
    endproperty
    a_hex_nosign: assert property (p_hex_nosign) else $error("points lit in hex");
endmodule

bind panel_monitor_display_diag panel_checker i_panel_checker (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .CLK_EN(CLK_EN), .KEY_UP(KEY_UP), .KEY_DOWN(KEY_DOWN),
    .SERVO_ON(SERVO_ON), .SPECIAL_FUNCTION_WR(SPECIAL_FUNCTION_WR), .SPECIAL_FUNCTION_PARAM(SPECIAL_FUNCTION_PARAM),
    .FORCE_PATTERN_WR(FORCE_PATTERN_WR), .FORCE_PATTERN_DATA(FORCE_PATTERN_DATA), .NORMAL_OUTPUTS(NORMAL_OUTPUTS),
    .DIGITAL_OUTPUTS_1_TO_6(DIGITAL_OUTPUTS_1_TO_6), .FORCE_ACTIVE(FORCE_ACTIVE),
    .OUTPUT_FORCE_PATTERN(OUTPUT_FORCE_PATTERN), .JOG_ACTIVE(JOG_ACTIVE), .JOG_FWD(JOG_FWD), .JOG_REV(JOG_REV),
    .DISP_GLYPHS(DISP_GLYPHS), .DISP_POINTS(DISP_POINTS), .DISP_HEX(DISP_HEX)
);

// file: sim/panel_monitor_display_diag_tb.sv
// Self-checking bench for the panel block: formats, fault view, jog and forced outputs.
// Assumes the keypad model and the bench change inputs only at falling edges.
`timescale 1ns/1ps
`include "panel_regs.vh"
module panel_monitor_display_diag_tb;
    localparam K_SET = 0, K_MODE = 1, K_UP = 2, K_DOWN = 3, K_SHIFT = 4;
    reg         clk = 1'b0, rst = 1'b1, en = 1'b1, sfw = 1'b0, fpw = 1'b0, servo = 1'b0;
    reg         pp = 1'b0, m32 = 1'b0, msg = 1'b0, p32 = 1'b0, phex = 1'b0, psg = 1'b0;
    reg  [15:0] sfp = 16'h0000;
    reg  [5:0]  fpd = 6'h00, nout = 6'h2A;
    reg  [2:0]  sel = 3'h7;
    reg  [1:0]  diag = `DIAG_NONE;
    reg  [8:0]  din = 9'h000;
    reg  [31:0] mv = 32'h0000_0000, pv = 32'h0000_0000;
    reg  [79:0] fh = 80'hFFFF_0063_0D2F_0010_0005;
    reg  [79:0] fx = 80'h5535_0099_3375_0016_0005;
    wire [4:0]  keys, pts;
    wire [5:0]  dout, fpat;
    wire [15:0] jspd;
    wire [24:0] glyph;
    wire        force_on, jog_act, fwd, rev, hi, hx;
    integer     failures = 0, check_count = 0, i;

    always #2.5 clk = ~clk;

    operator_panel i_operator_panel (.clk(clk), .keys(keys));

    panel_monitor_display_diag i_panel_monitor_display_diag (
        .CLK_SYS(clk), .RESET(rst), .CLK_EN(en), .KEY_SET(keys[K_SET]), .KEY_MODE(keys[K_MODE]),
        .KEY_UP(keys[K_UP]), .KEY_DOWN(keys[K_DOWN]), .KEY_SHIFT(keys[K_SHIFT]), .MON_VALUE(mv),
        .MON_IS_32(m32), .MON_SIGNED(msg), .PANEL_PARAM(pp), .PARAM_SEL(sel), .PARAM_VALUE(pv),
        .PARAM_IS_32(p32), .PARAM_HEX(phex), .PARAM_SIGNED(psg), .FAULT_HISTORY_SLOTS(fh),
        .SPECIAL_FUNCTION_WR(sfw), .SPECIAL_FUNCTION_PARAM(sfp), .FORCE_PATTERN_WR(fpw),
        .FORCE_PATTERN_DATA(fpd), .SERVO_ON(servo), .DIAG_SEL(diag), .DIGITAL_INPUTS_1_TO_9(din),
        .NORMAL_OUTPUTS(nout), .DIGITAL_OUTPUTS_1_TO_6(dout), .FORCE_ACTIVE(force_on),
        .OUTPUT_FORCE_PATTERN(fpat), .JOG_SPEED_PARAM(jspd), .JOG_ACTIVE(jog_act), .JOG_FWD(fwd),
        .JOG_REV(rev), .DISP_GLYPHS(glyph), .DISP_POINTS(pts), .DISP_PAGE_HIGH(hi), .DISP_HEX(hx)
    );

    function [24:0] g(input [4:0] lead, input [15:0] h);
        g = {lead, 1'b0, h[15:12], 1'b0, h[11:8], 1'b0, h[7:4], 1'b0, h[3:0]};
    endfunction

    task chk(input [24:0] seen, input [24:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("BAD %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask

    // Long wait covers a full decimal conversion after any change
    task disp(input [24:0] gl, input [4:0] pt);
        begin
            cyc(70);
            chk(glyph, gl);
            chk(25'(pts), 25'(pt));
        end
    endtask

    task sf(input [15:0] code);
        begin
            sfp = code;
            sfw = 1'b1;
            cyc(1);
            sfw = 1'b0;
            cyc(2);
        end
    endtask

    task fp(input [5:0] pat);
        begin
            fpd = pat;
            fpw = 1'b1;
            cyc(1);
            fpw = 1'b0;
            cyc(2);
        end
    endtask

    task finish_test;
        begin
            $display("Checks %0d, mismatches %0d", check_count, failures);
            if (failures == 0 && check_count > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures = failures + 1;
        finish_test;
    end

    initial begin
        cyc(12);
        rst = 1'b0;
        cyc(2);
        chk(25'(jspd), 25'h14);
        chk(25'(dout), 25'h2A);
        fp(6'h02);
        sf(`SF_FORCE_ON);
        chk(25'(force_on), 25'h1);
        chk(25'(dout), 25'h02);
        fp(6'h05);
        chk(25'(dout), 25'h05);
        chk(25'(fpat), 25'h05);
        // A pattern write while the clock enable is low must not land
        en = 1'b0;
        fp(6'h3F);
        en = 1'b1;
        chk(25'(fpat), 25'h05);
        pp = 1'b1;
        sel = `SEL_FORCE_PAT;
        pv = 32'h0000_0005;
        phex = 1'b1;
        disp(g(`GLYPH_BLANK, 16'h0005), `DP_NONE);
        sf(16'h0123);
        chk(25'(force_on), 25'h1);
        sf(`SF_FORCE_OFF);
        chk(25'(dout), 25'h2A);
        diag = `DIAG_OUTPUTS;
        disp(g(`GLYPH_BLANK, 16'h002A), `DP_NONE);
        diag = `DIAG_INPUTS;
        din = 9'h1E1;
        disp(g(`GLYPH_BLANK, 16'h01E1), `DP_NONE);
        diag = `DIAG_NONE;
        sel = 3'h7;
        pv = 32'h0000_1234;
        disp(g(`GLYPH_BLANK, 16'h1234), `DP_NONE);
        i_operator_panel.press(K_SET);
        disp(g(`GLYPH_BLANK, 16'h1234), `DP_NONE);
        phex = 1'b0;
        pv = 32'h0000_04D2;
        disp(g(5'h00, 16'h1234), `DP_NONE);
        psg = 1'b1;
        pv = 32'hFFFF_CFC7;
        disp(g(5'h01, 16'h2345), `DP_NEGATIVE);
        phex = 1'b1;
        disp(g(`GLYPH_BLANK, 16'hCFC7), `DP_NONE);
        p32 = 1'b1;
        phex = 1'b0;
        pv = 32'h4996_02D2;
        disp(g(5'h06, 16'h7890), `DP_NONE);
        for (i = 0; i < 5; i = i + 1) begin
            sel = i[2:0];
            i_operator_panel.press(K_SET);
            disp(g((i == 4) ? 5'h06 : 5'h00, fx[16 * i +: 16]), `DP_NONE);
            i_operator_panel.press(K_MODE);
        end
        sel = `SEL_JOG_SPEED;
        i_operator_panel.press(K_SET);
        disp(g(5'h00, 16'h0020), `DP_NONE);
        i_operator_panel.press(K_UP);
        i_operator_panel.press(K_UP);
        i_operator_panel.press(K_DOWN);
        chk(25'(jspd), 25'h15);
        i_operator_panel.press(K_SET);
        chk(25'(jog_act), 25'h1);
        i_operator_panel.hold(5'h04);
        cyc(3);
        chk(25'({fwd, rev}), 25'h0);
        servo = 1'b1;
        cyc(2);
        chk(25'({fwd, rev}), 25'h2);
        i_operator_panel.hold(5'h00);
        cyc(1);
        chk(25'({fwd, rev}), 25'h0);
        i_operator_panel.hold(5'h08);
        cyc(2);
        chk(25'({fwd, rev}), 25'h1);
        i_operator_panel.hold(5'h0C);
        cyc(2);
        chk(25'({fwd, rev}), 25'h0);
        i_operator_panel.hold(5'h00);
        i_operator_panel.press(K_MODE);
        chk(25'(jog_act), 25'h0);
        pp = 1'b0;
        m32 = 1'b1;
        mv = 32'h4996_02D2;
        disp(g(5'h06, 16'h7890), `DP_NONE);
        i_operator_panel.press(K_SHIFT);
        disp(g(5'h01, 16'h2345), `DP_HIGH_PAGE);
        chk(25'(hi), 25'h1);
        msg = 1'b1;
        mv = 32'hB669_FD2E;
        disp(g(5'h01, 16'h2345), `DP_HIGH_PAGE | `DP_NEGATIVE);
        i_operator_panel.press(K_SET);
        mv = 32'h1234_5678;
        disp(g(`GLYPH_HIGH, 16'h1234), `DP_NONE);
        chk(25'(hx), 25'h1);
        i_operator_panel.press(K_SHIFT);
        disp(g(`GLYPH_LOW, 16'h5678), `DP_NONE);
        // Forcing must not survive a reset in mid-run
        sf(`SF_FORCE_ON);
        chk(25'(force_on), 25'h1);
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        cyc(2);
        chk(25'(force_on), 25'h0);
        chk(25'(dout), 25'h2A);
        chk(25'(jspd), 25'h14);
        finish_test;
    end
endmodule
